/* File: shared/pdp_pkg.sv */
// Constants, types and register map of the program and debug port registers
//
// Notes on behaviour
// - Error signature field is set on a port error and cleared by a debugger read.
// - Signature codes: 0 none, 1 parity, 2 stop bits, 3 no answer, 4 start, 7 contention.
// - Inter-byte delay puts two idle characters between sent bytes; guard time first.
// - Parity disable ignores the parity bit and reports no parity errors.
// - Flag a time-out after 65536 cycles without answer unless time-out detect is off.
// - Response signature disable suppresses every response signature the port sends.
// - Guard time on receive-to-transmit: code 0 is 128 cycles, halving; code 7 none.
// - Send a NACK when system reset hits a busy load or store, unless NACK is off.
// - Contention detect disable stops collision and contention detection on the line.
// - Port disable drops the clock request and resets physical configuration and keys.
// - Key status bits 5, 4, 3 read one while that key is active.
// - Programming key clears when programming ends; erase key clears when erase ends.
// - Writing 0x59 holds a system reset, port untouched; any other value releases it.
// - Reset request read returns held reset in bit 0, zero elsewhere.
// - Clock select 1 is 16 MHz, 2 is 8 MHz, 3 is 4 MHz; 0 is reserved.
// - User-row done is writable only with the user-row key; the write starts the copy.
// - System clock request keeps the clock; set on port enable, cleared on disable; reset clears it with the port enabled, and a wake or a write sets it.
// - System reset active flag is set during system reset and cleared on read.
// - In-sleep flag reads one while the system domain sleeps.
// - Programming ready flag says programming may start; set once the debugger has cycled system reset.
// - User-row ready flag says user-row programming may start; debugger then writes done.
// - Lock flag reads one while locked, zero after erase clears the lock bits.
`default_nettype none
package pdp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_ERR = 4'h1;
    localparam logic [3:0] OFF_PHYCTL = 4'h2;
    localparam logic [3:0] OFF_PHYOPT = 4'h3;
    localparam logic [3:0] OFF_KEY = 4'h7;
    localparam logic [3:0] OFF_RESETREQ = 4'h8;
    localparam logic [3:0] OFF_CLKSEL = 4'h9;
    localparam logic [3:0] OFF_SYSCTL = 4'ha;
    localparam logic [3:0] OFF_SYSSTAT = 4'hb;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_INTERBYTE = 7;
    localparam int B_PAROFF = 5;
    localparam int B_TOOFF = 4;
    localparam int B_RSPOFF = 3;
    localparam int B_NACKOFF = 4;
    localparam int B_CCOFF = 3;
    localparam int B_PORTDIS = 2;
    localparam int B_UROWKEY = 5;
    localparam int B_NVMKEY = 4;
    localparam int B_ERASEKEY = 3;
    localparam int B_RSTHELD = 0;
    localparam int B_URDONE = 1;
    localparam int B_CLOCKREQ = 0;
    localparam int B_SYSRST = 5;
    localparam int B_SLEEP = 4;
    localparam int B_NVMRDY = 3;
    localparam int B_URRDY = 2;
    localparam int B_LOCK = 0;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [1:0] RST_CLKSEL = 2'h2;
    localparam logic [1:0] CLK_RSVD = 2'h0;
    localparam logic [7:0] RESET_SIGNATURE = 8'h59;
    localparam logic [2:0] GUARD_OFF = 3'h7;
    localparam int GUARD_MAX_CYCLES = 128;
    localparam int IDLE_CHAR_BITS = 12;
    localparam int IBD_CHARS = 2;
    localparam int TIMEOUT_CYCLES = 65536;

    typedef enum logic [2:0] {
        ERR_NONE = 3'h0,
        ERR_PARITY = 3'h1,
        ERR_FRAME = 3'h2,
        ERR_TIMEOUT = 3'h3,
        ERR_START = 3'h4,
        ERR_CONTENTION = 3'h7
    } pdp_err_t;

    typedef struct packed {
        logic interByte;
        logic parityOff;
        logic timeoutOff;
        logic respSigOff;
        logic [2:0] guardSel;
    } pdp_phy_cfg_t;

    typedef struct packed {
        logic contention;
        logic startBit;
        logic frame;
        logic parity;
    } pdp_line_err_t;

    typedef struct packed {
        logic contention;
        logic startBit;
        logic timeout;
        logic frame;
        logic parity;
    } pdp_err_ev_t;
endpackage
`default_nettype wire

/* File: hw/pdp_countdown.sv */
// Loadable down-counter that pulses when the loaded delay has run out
`timescale 1ns/10ps
`default_nettype none
module pdp_countdown #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic stop,
    input wire logic [W-1:0] loadVal,
    // Status
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_q;
    logic busy_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            busy_q <= 1'h0;
        end else if (load) begin
            cnt_q <= loadVal;
            busy_q <= 1'h1;
        end else if (stop || (busy_q && cnt_q == '0)) begin
            busy_q <= 1'h0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy = busy_q;
    assign done = busy_q && (cnt_q == '0) && !stop;
endmodule
`default_nettype wire

/* File: hw/pdp_err_encode.sv */
// Priority encoder from port error events to the error signature code
`timescale 1ns/10ps
`default_nettype none
module pdp_err_encode
    import pdp_pkg::*;
(
    // Events
    input wire pdp_err_ev_t events,
    // Code
    output logic valid,
    output var pdp_err_t code
);
    assign valid = |events;
    // Only the listed codes are ever produced
    assign code = events.contention ? ERR_CONTENTION :
                  events.startBit ? ERR_START :
                  events.frame ? ERR_FRAME :
                  events.parity ? ERR_PARITY :
                  events.timeout ? ERR_TIMEOUT : ERR_NONE;
endmodule
`default_nettype wire

/* File: hw/pdp_regs.sv */
// Control and status registers of the single-wire program and debug port
`timescale 1ns/10ps
`default_nettype none
module pdp_regs
    import pdp_pkg::*;
#(
    parameter int TIMEOUT_LEN = TIMEOUT_CYCLES,
    parameter int BIT_CYCLES = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access from the instruction layer
    input wire logic [3:0] regAddr,
    input wire logic regWe,
    input wire logic regRe,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Physical layer
    input wire pdp_line_err_t lineErr,
    input wire logic txDirSwitch,
    input wire logic txNextByte,
    output logic txGrant,
    output logic respSigEnable,
    output logic parityCheckEn,
    output logic contentionCheckEn,
    // Access layer
    input wire logic accessRequest,
    input wire logic accessResponse,
    input wire logic accessBusy,
    output logic sendNack,
    // Key decoder and programming engine
    input wire logic keyUrowDecoded,
    input wire logic keyNvmDecoded,
    input wire logic keyEraseDecoded,
    input wire logic nvmProgDone,
    input wire logic eraseDone,
    input wire logic urowCopyDone,
    output logic urowCommit,
    // System domain
    input wire logic sysInReset,
    input wire logic sysSleeping,
    input wire logic lockBitsSet,
    output logic sysResetReq,
    output logic sysClockRequest,
    // Port clock and enable
    input wire logic portWake,
    output logic [1:0] portClockSel,
    output logic portClockRequest
);
    localparam int GW = 10;
    localparam int TW = 18;
    localparam logic [GW-1:0] IBD_LOAD = GW'(IBD_CHARS * IDLE_CHAR_BITS * BIT_CYCLES - 1);
    localparam logic [TW-1:0] TO_LOAD = TW'(TIMEOUT_LEN - 1);

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    function automatic logic [GW-1:0] guardLoad(input logic [2:0] sel);
        logic [GW-1:0] len;
        len = GW'(GUARD_MAX_CYCLES) >> sel;
        return (sel == GUARD_OFF) ? '0 : len - GW'(1);
    endfunction

    wire logic wrCtl = regWe && hit(regAddr, OFF_PHYCTL);
    wire logic wrOpt = regWe && hit(regAddr, OFF_PHYOPT);
    wire logic wrKey = regWe && hit(regAddr, OFF_KEY);
    wire logic wrRst = regWe && hit(regAddr, OFF_RESETREQ);
    wire logic wrClk = regWe && hit(regAddr, OFF_CLKSEL);
    wire logic wrSys = regWe && hit(regAddr, OFF_SYSCTL);
    wire logic rdErr = regRe && hit(regAddr, OFF_ERR);
    wire logic rdStat = regRe && hit(regAddr, OFF_SYSSTAT);
    wire logic portDisable = wrOpt && regWdata[B_PORTDIS];
    wire logic rstSigWr = regWdata == RESET_SIGNATURE;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pdp_phy_cfg_t phyCfg_q;
    logic nackOff_q;
    logic ccOff_q;
    logic portEn_q;
    logic system_clock_request_q;
    logic urowKey_q;
    logic nvmKey_q;
    logic eraseKey_q;
    logic system_reset_request_q;
    logic [1:0] clkSel_q;
    logic system_reset_active_q;
    logic nvmRdy_q;
    logic urowRdy_q;
    logic urowCommit_q;
    logic sendNack_q;
    logic sysRstSeen_q;
    logic [2:0] errSig_q;
    logic [7:0] rdata_q;
    logic errValid;
    pdp_err_t errCode;
    logic toDone;
    logic guardDone;

    // Physical configuration, cleared by port disable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phyCfg_q <= '0;
            nackOff_q <= 1'h0;
            ccOff_q <= 1'h0;
        end else if (portDisable) begin
            phyCfg_q <= '0;
            nackOff_q <= 1'h0;
            ccOff_q <= 1'h0;
        end else begin
            if (wrCtl) begin
                phyCfg_q <= '{regWdata[B_INTERBYTE], regWdata[B_PAROFF], regWdata[B_TOOFF],
                              regWdata[B_RSPOFF], regWdata[2:0]};
            end
            if (wrOpt) begin
                nackOff_q <= regWdata[B_NACKOFF];
                ccOff_q <= regWdata[B_CCOFF];
            end
        end
    end

    // Port enable and system clock request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            portEn_q <= 1'h1;
            system_clock_request_q <= 1'h0;
        end else if (portDisable) begin
            portEn_q <= 1'h0;
            system_clock_request_q <= 1'h0;
        end else if (portWake) begin
            portEn_q <= 1'h1;
            system_clock_request_q <= 1'h1;
        end else if (wrSys) begin
            system_clock_request_q <= regWdata[B_CLOCKREQ];
        end
    end

    // Keys: a decode wins over a same-cycle done or key-register clear; port disable wins over a decode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            urowKey_q <= 1'h0;
            nvmKey_q <= 1'h0;
            eraseKey_q <= 1'h0;
        end else if (portDisable) begin
            urowKey_q <= 1'h0;
            nvmKey_q <= 1'h0;
            eraseKey_q <= 1'h0;
        end else begin
            urowKey_q <= keyUrowDecoded || (urowKey_q && !(wrKey && regWdata[B_UROWKEY]));
            nvmKey_q <= keyNvmDecoded || (nvmKey_q && !nvmProgDone);
            eraseKey_q <= keyEraseDecoded || (eraseKey_q && !eraseDone);
        end
    end

    // System reset request and clock select
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            system_reset_request_q <= 1'h0;
            clkSel_q <= RST_CLKSEL;
        end else begin
            if (wrRst) begin
                system_reset_request_q <= rstSigWr;
            end
            if (wrClk && regWdata[1:0] != CLK_RSVD) begin
                clkSel_q <= regWdata[1:0];
            end
        end
    end

    // Programming readiness follows a system reset cycled under a key
    wire logic rstRelease = system_reset_request_q && wrRst && !rstSigWr;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nvmRdy_q <= 1'h0;
            urowRdy_q <= 1'h0;
            urowCommit_q <= 1'h0;
        end else begin
            nvmRdy_q <= nvmKey_q && (nvmRdy_q || rstRelease);
            urowRdy_q <= urowKey_q && (rstRelease || (urowRdy_q && !urowCopyDone));
            urowCommit_q <= wrSys && regWdata[B_URDONE] && urowKey_q;
        end
    end

    // Sticky status: a new event wins over the read that clears it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            system_reset_active_q <= 1'h0;
            errSig_q <= ERR_NONE;
            sysRstSeen_q <= 1'h0;
            sendNack_q <= 1'h0;
        end else begin
            system_reset_active_q <= sysInReset || system_reset_request_q || (system_reset_active_q && !rdStat);
            if (errValid) begin
                errSig_q <= errCode;
            end else if (rdErr || portDisable) begin
                errSig_q <= ERR_NONE;
            end
            sysRstSeen_q <= sysInReset;
            sendNack_q <= sysInReset && !sysRstSeen_q && accessBusy
                          && !nackOff_q && portEn_q;
        end
    end

    // ------------------------------------------------------------
    // Error capture
    // ------------------------------------------------------------
    wire pdp_err_ev_t errEvents = '{
        contention: lineErr.contention && !ccOff_q && portEn_q,
        startBit: lineErr.startBit && portEn_q,
        timeout: toDone && !phyCfg_q.timeoutOff && portEn_q,
        frame: lineErr.frame && portEn_q,
        parity: lineErr.parity && !phyCfg_q.parityOff && portEn_q
    };

    pdp_err_encode u_err (
        .events(errEvents),
        .valid(errValid),
        .code(errCode)
    );

    // ------------------------------------------------------------
    // Access layer time-out
    // ------------------------------------------------------------
    pdp_countdown #(.W(TW)) u_timeout (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(accessRequest && !phyCfg_q.timeoutOff),
        .stop(accessResponse || portDisable),
        .loadVal(TO_LOAD),
        .busy(),
        .done(toDone)
    );

    // ------------------------------------------------------------
    // Guard time and inter-byte spacing
    // ------------------------------------------------------------
    wire logic guardStart = txDirSwitch || txNextByte;
    wire logic [GW-1:0] guardVal = txDirSwitch ? guardLoad(phyCfg_q.guardSel) :
                                phyCfg_q.interByte ? IBD_LOAD : '0;

    pdp_countdown #(.W(GW)) u_guard (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(guardStart),
        .stop(portDisable),
        .loadVal(guardVal),
        .busy(),
        .done(guardDone)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [7:0] ctlByte = {phyCfg_q.interByte, 1'h0, phyCfg_q.parityOff,
                                phyCfg_q.timeoutOff, phyCfg_q.respSigOff, phyCfg_q.guardSel};
    wire logic [7:0] optByte = {3'h0, nackOff_q, ccOff_q, 3'h0};
    wire logic [7:0] keyByte = {2'h0, urowKey_q, nvmKey_q, eraseKey_q, 3'h0};
    wire logic [7:0] statByte = {2'h0, system_reset_active_q, sysSleeping, nvmRdy_q,
                                 urowRdy_q, 1'h0, lockBitsSet};
    wire logic [7:0] rdMux =
        hit(regAddr, OFF_ERR) ? {5'h0, errSig_q} :
        hit(regAddr, OFF_PHYCTL) ? ctlByte :
        hit(regAddr, OFF_PHYOPT) ? optByte :
        hit(regAddr, OFF_KEY) ? keyByte :
        hit(regAddr, OFF_RESETREQ) ? {7'h0, system_reset_request_q} :
        hit(regAddr, OFF_CLKSEL) ? {6'h0, clkSel_q} :
        hit(regAddr, OFF_SYSCTL) ? {7'h0, system_clock_request_q} :
        hit(regAddr, OFF_SYSSTAT) ? statByte : 8'h00;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (regRe) begin
            rdata_q <= rdMux;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdata = rdata_q;
    assign txGrant = guardDone && portEn_q;
    assign respSigEnable = !phyCfg_q.respSigOff && portEn_q;
    assign parityCheckEn = !phyCfg_q.parityOff && portEn_q;
    assign contentionCheckEn = !ccOff_q && portEn_q;
    assign sendNack = sendNack_q;
    assign urowCommit = urowCommit_q;
    assign sysResetReq = system_reset_request_q;
    assign sysClockRequest = system_clock_request_q;
    assign portClockSel = clkSel_q;
    assign portClockRequest = portEn_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence guardStartMax;
        txDirSwitch && phyCfg_q.guardSel == 3'h0 && portEn_q && !portDisable;
    endsequence

    sequence quietLoad;
        !guardStart && !portDisable && !wrOpt;
    endsequence

    err_read_clear_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        rdErr && !errValid |=> errSig_q == 3'h0)
        else $error("error signature not cleared by read");

    err_code_legal_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        errSig_q != 3'h5 && errSig_q != 3'h6)
        else $error("reserved error signature produced");

    guard_max_wait_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        guardStartMax ##1 quietLoad [*8] |-> !txGrant)
        else $error("guard time ended too early");

    guard_off_now_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        txDirSwitch && phyCfg_q.guardSel == GUARD_OFF && portEn_q && !portDisable
        |=> txGrant || portDisable)
        else $error("no grant one cycle after switch with guard off");

    parity_quiet_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        phyCfg_q.parityOff && errSig_q != 3'h1 |=> errSig_q != 3'h1)
        else $error("parity error reported while parity is off");

    timeout_flag_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        toDone && !phyCfg_q.timeoutOff && portEn_q |=> errSig_q != 3'h0)
        else $error("time-out not flagged");

    nack_off_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(sendNack) |-> $past(!nackOff_q && accessBusy && sysInReset))
        else $error("nack sent without its cause");

    reset_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wrRst && rstSigWr |=> sysResetReq && (!hit(regAddr, OFF_RESETREQ) || rdMux == 8'h01)
        ##1 system_reset_active_q)
        else $error("reset request not held");

    clk_reserved_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wrClk && regWdata[1:0] == CLK_RSVD |=> $stable(portClockSel))
        else $error("reserved clock code changed selection");

    port_disable_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        portDisable |=> !portClockRequest && !sysClockRequest && keyByte == 8'h00)
        else $error("port disable did not reset port state");

    sys_reset_flag_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        sysInReset |=> system_reset_active_q)
        else $error("system reset flag not set");
endmodule
`default_nettype wire

/* File: sim/pdp_sys_model.sv */
// System domain model that answers the port's reset request, sleep and lock state
`timescale 1ns/10ps
`default_nettype none
module pdp_sys_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Port side
    input wire logic sysResetReq,
    input wire logic sleepIn,
    input wire logic lockIn,
    // System state
    output logic sysInReset,
    output logic sysSleeping,
    output logic lockBitsSet
);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sysInReset <= 1'h0;
        end else begin
            sysInReset <= sysResetReq;
        end
    end
    assign sysSleeping = sleepIn;
    assign lockBitsSet = lockIn;
endmodule
`default_nettype wire

/* File: sim/pdp_regs_tb_top.sv */
// Self-checking bench for the port register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pdp_regs_tb_top import pdp_pkg::*;;
    localparam int BITC = 4;
    localparam logic [3:0] RA [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    localparam logic [7:0] RE [9] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h2, 8'h0, 8'h1};
    logic sys_clk = 1'h0, rst = 1'h1, regWe = 1'h0, regRe = 1'h0, txDirSwitch = 1'h0;
    logic txNextByte = 1'h0, accessRequest = 1'h0, accessResponse = 1'h0, accessBusy = 1'h0;
    logic keyUrowDecoded = 1'h0, keyNvmDecoded = 1'h0, keyEraseDecoded = 1'h0;
    logic nvmProgDone = 1'h0, eraseDone = 1'h0, urowCopyDone = 1'h0, portWake = 1'h0;
    logic sleepIn = 1'h0, lockIn = 1'h1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h0, regRdata, d;
    pdp_line_err_t lineErr = '0;
    logic txGrant, respSigEnable, parityCheckEn, contentionCheckEn, sendNack, urowCommit;
    logic sysResetReq, sysClockRequest, portClockRequest, sysInReset, sysSleeping, lockBitsSet;
    logic [1:0] portClockSel;
    int errors = 0, checked = 0, n, nackCnt = 0;

    pdp_regs #(.TIMEOUT_LEN(16), .BIT_CYCLES(BITC)) dut_u (.sys_clk, .rst, .regAddr, .regWe,
        .regRe, .regWdata, .regRdata, .lineErr, .txDirSwitch, .txNextByte, .txGrant,
        .respSigEnable, .parityCheckEn, .contentionCheckEn, .accessRequest, .accessResponse,
        .accessBusy,
        .sendNack, .keyUrowDecoded, .keyNvmDecoded, .keyEraseDecoded, .nvmProgDone, .eraseDone,
        .urowCopyDone, .urowCommit, .sysInReset, .sysSleeping, .lockBitsSet, .sysResetReq,
        .sysClockRequest, .portWake, .portClockSel, .portClockRequest);
    pdp_sys_model sys_u (.sys_clk, .rst, .sysResetReq, .sleepIn, .lockIn, .sysInReset,
        .sysSleeping, .lockBitsSet);

    always #25 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (sendNack === 1'h1) nackCnt++;
    end

    function automatic int guardCycles(input int c);
        return (c == 7) ? 1 : (128 >> c);
    endfunction
    function automatic logic [7:0] errCode(input int i);
        return (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'h04 : 8'h07;
    endfunction

    task automatic give_verdict();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        regAddr = a;
        regWdata = v;
        regWe = 1'h1;
        @(negedge sys_clk);
        regWe = 1'h0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regAddr = a;
        regRe = 1'h1;
        @(negedge sys_clk);
        regRe = 1'h0;
        `CHK(regRdata, e)
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'h1;
        @(negedge sys_clk);
        s = 1'h0;
    endtask
    task automatic errPulse(input logic [3:0] v);
        @(negedge sys_clk);
        lineErr = pdp_line_err_t'(v);
        @(negedge sys_clk);
        lineErr = '0;
    endtask
    // Counts cycles from the trigger edge to the send grant
    task automatic grant(ref logic s, input int e);
        pulse(s);
        n = 1;
        while (txGrant !== 1'h1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(n, e)
        if (n >= 300) give_verdict();
    endtask

    initial begin
        void'($urandom(29311));
        repeat (2) @(negedge sys_clk);
        rst = 1'h0;
        foreach (RA[i]) rdc(RA[i], RE[i]);
        for (int i = 0; i < 4; i++) begin
            errPulse(4'h1 << i);
            rdc(4'h1, errCode(i));
            rdc(4'h1, 8'h00);
        end
        repeat (8) begin
            d = 8'($urandom);
            wr(4'h2, d);
            rdc(4'h2, d & 8'hbf);
            `CHK(parityCheckEn, ~d[5])
            `CHK(respSigEnable, ~d[3])
        end
        wr(4'h2, 8'h20);
        errPulse(4'h1);
        rdc(4'h1, 8'h00);
        wr(4'h3, 8'h08);
        `CHK(contentionCheckEn, 1'h0)
        errPulse(4'h8);
        rdc(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        pulse(accessRequest);
        repeat (20) @(negedge sys_clk);
        rdc(4'h1, 8'h03);
        wr(4'h2, 8'h10);
        pulse(accessRequest);
        repeat (20) @(negedge sys_clk);
        rdc(4'h1, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(4'h2, 8'(c));
            grant(txDirSwitch, guardCycles(c));
        end
        wr(4'h2, 8'h87);
        grant(txNextByte, IBD_CHARS * IDLE_CHAR_BITS * BITC);
        wr(4'h2, 8'h07);
        grant(txNextByte, 1);
        for (int c = 1; c < 4; c++) begin
            wr(4'h9, 8'(c));
            rdc(4'h9, 8'(c));
            `CHK(portClockSel, 2'(c))
        end
        wr(4'h9, 8'h00);
        rdc(4'h9, 8'h03);
        wr(4'h5, 8'hff);
        rdc(4'h5, 8'h00);
        pulse(keyEraseDecoded);
        rdc(4'h7, 8'h08);
        pulse(eraseDone);
        rdc(4'h7, 8'h00);
        pulse(keyUrowDecoded);
        rdc(4'h7, 8'h20);
        wr(4'ha, 8'h03);
        `CHK(urowCommit, 1'h1)
        wr(4'h7, 8'h20);
        rdc(4'h7, 8'h00);
        wr(4'ha, 8'h03);
        `CHK(urowCommit, 1'h0)
        rdc(4'ha, 8'h01);
        `CHK(sysClockRequest, 1'h1)
        accessBusy = 1'h1;
        pulse(keyNvmDecoded);
        wr(4'h8, RESET_SIGNATURE);
        `CHK(sysResetReq, 1'h1)
        rdc(4'h8, 8'h01);
        rdc(4'hb, 8'h21);
        d = 8'($urandom);
        if (d == RESET_SIGNATURE) d = 8'h00;
        wr(4'h8, d);
        `CHK(sysResetReq, 1'h0)
        repeat (3) @(negedge sys_clk);
        rdc(4'hb, 8'h29);
        rdc(4'hb, 8'h09);
        `CHK(nackCnt, 1)
        pulse(nvmProgDone);
        rdc(4'hb, 8'h01);
        wr(4'h3, 8'h10);
        wr(4'h8, RESET_SIGNATURE);
        wr(4'h8, 8'h00);
        repeat (3) @(negedge sys_clk);
        `CHK(nackCnt, 1)
        rdc(4'hb, 8'h21);
        accessBusy = 1'h0;
        sleepIn = 1'h1;
        rdc(4'hb, 8'h11);
        sleepIn = 1'h0;
        lockIn = 1'h0;
        rdc(4'hb, 8'h00);
        wr(4'h2, 8'h55);
        wr(4'h3, 8'h04);
        `CHK(portClockRequest, 1'h0)
        `CHK(sysClockRequest, 1'h0)
        pulse(portWake);
        `CHK(sysClockRequest, 1'h1)
        rdc(4'h2, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
